// ### pkg/pin_sel_pkg.sv
// Constants for the DAC pin and weak pull-down selection registers
package pin_sel_pkg;
  localparam int          REG_W          = 16;
  localparam int          PIN_N          = 8;
  // Register indices on the internal register port
  localparam logic [1:0]  IDX_DAC_SEL    = 2'h0;
  localparam logic [1:0]  IDX_PD_SEL     = 2'h1;
  localparam logic [1:0]  IDX_GEN_CTRL   = 2'h2;
  localparam logic [15:0] DAC_SEL_RST    = 16'h0000;
  localparam logic [15:0] PD_SEL_RST     = 16'h00FF;
  localparam logic [15:0] GEN_CTRL_RST   = 16'h0000;
  localparam int          LOCK_BIT       = 7;
  localparam logic [15:0] SEL_WR_MASK    = 16'h00FF;
  localparam logic [15:0] UNMAPPED_RDATA = 16'h0000;
endpackage : pin_sel_pkg

// ### rtl/sel_reg_bank.sv
// Small register bank holding the two pin selection words
`timescale 1ns/1ps
module sel_reg_bank #(
  parameter int W = 16
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic         wr_en_i,
  input  wire logic         wr_idx_i,
  input  wire logic [W-1:0] wr_data_i,
  input  wire logic         rd_idx_i,
  output logic      [W-1:0] rd_data_o,
  output logic      [W-1:0] word0_o,
  output logic      [W-1:0] word1_o
);
  logic [W-1:0] word0_r;
  logic [W-1:0] word1_r;

  // [R03] DAC select clear
  // [R06] Pull-downs all on
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      word0_r <= W'(pin_sel_pkg::DAC_SEL_RST);
      word1_r <= W'(pin_sel_pkg::PD_SEL_RST);
    end else if (wr_en_i) begin
      // [R04] Upper byte masked
      if (wr_idx_i) word1_r <= wr_data_i & W'(pin_sel_pkg::SEL_WR_MASK);
      else          word0_r <= wr_data_i & W'(pin_sel_pkg::SEL_WR_MASK);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) rd_data_o <= '0;
    else           rd_data_o <= rd_idx_i ? word1_r : word0_r;
  end

  assign word0_o = word0_r;
  assign word1_o = word1_r;
endmodule : sel_reg_bank

// ### rtl/dac_pin_select_and_pulldown_cfg.sv
// DAC output and weak pull-down pin selection registers
// Overview of operation
// [R01] DAC select bit n makes pin n analog
// [R02] Cleared bit leaves pin to others
// [R03] DAC select resets to zero
// [R04] Upper byte reserved, reads zero
// [R05] Pull-down bit n grounds pin n weakly
// [R06] Pull-down select resets to 0x00FF
// [R07] Low byte bits are read/write
// [R08] Lock bit refuses selection writes
// [R09] Writes to upper byte ignored
`timescale 1ns/1ps
module dac_pin_select_and_pulldown_cfg #(
  parameter int PINS = pin_sel_pkg::PIN_N
) (
  input  wire logic            clk_i,
  input  wire logic            resetn_i,
  input  wire logic            reg_wr_i,
  input  wire logic            reg_rd_i,
  input  wire logic [1:0]      reg_idx_i,
  input  wire logic [15:0]     reg_wdata_i,
  output logic      [15:0]     reg_rdata_o,
  output logic                 reg_rvalid_o,
  output logic                 wr_refused_o,
  output logic      [PINS-1:0] analog_out_sel_o,
  output logic      [PINS-1:0] weak_gnd_sel_o,
  output logic                 cfg_locked_o
);
  logic [15:0]     gen_ctrl_r;
  logic [15:0]     gen_ctrl_nxt;
  logic [15:0]     bank_rdata;
  logic [15:0]     dac_word;
  logic [15:0]     pd_word;
  logic            sel_hit;
  logic            ctrl_hit;
  logic            pd_hit;
  logic            sel_wr;
  logic            sel_wr_refused;
  logic            lock;
  logic            rd_pend_r;
  logic            rd_pend_nxt;
  logic [1:0]      rd_idx_r;
  logic [1:0]      rd_idx_nxt;
  logic [15:0]     rdata_r;
  logic [15:0]     rdata_nxt;
  logic            rvalid_r;
  logic            refused_r;
  logic [PINS-1:0] analog_sel_r;
  logic [PINS-1:0] analog_sel_nxt;
  logic [PINS-1:0] weak_gnd_r;
  logic [PINS-1:0] weak_gnd_nxt;
  logic            locked_r;

  // Register index decode, shared by write and read paths
  function automatic logic is_dac_idx(input logic [1:0] idx);
    return idx == pin_sel_pkg::IDX_DAC_SEL;
  endfunction : is_dac_idx

  function automatic logic is_pd_idx(input logic [1:0] idx);
    return idx == pin_sel_pkg::IDX_PD_SEL;
  endfunction : is_pd_idx

  function automatic logic is_ctrl_idx(input logic [1:0] idx);
    return idx == pin_sel_pkg::IDX_GEN_CTRL;
  endfunction : is_ctrl_idx

  function automatic logic is_sel_idx(input logic [1:0] idx);
    return is_dac_idx(idx) || is_pd_idx(idx);
  endfunction : is_sel_idx

  // Pin claims sit in the low bits of a selection word
  function automatic logic [PINS-1:0] pin_claims(input logic [15:0] word);
    return word[PINS-1:0];
  endfunction : pin_claims

  assign lock     = gen_ctrl_r[pin_sel_pkg::LOCK_BIT];
  assign sel_hit  = is_sel_idx(reg_idx_i);
  assign ctrl_hit = is_ctrl_idx(reg_idx_i);
  assign pd_hit   = is_pd_idx(reg_idx_i);

  // Index 2 is a stand-in control word; only its lock bit acts here
  // [R08] Locked writes dropped, refusal reported
  assign sel_wr         = reg_wr_i && sel_hit && !lock;
  assign sel_wr_refused = reg_wr_i && sel_hit && lock;

  // Lock register itself stays writable so software can unlock
  always_comb begin
    gen_ctrl_nxt = gen_ctrl_r;
    if (reg_wr_i && ctrl_hit) begin
      gen_ctrl_nxt = reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      gen_ctrl_r <= pin_sel_pkg::GEN_CTRL_RST;
    end else begin
      gen_ctrl_r <= gen_ctrl_nxt;
    end
  end

  // [R07] Stored and read back
  // [R09] Upper byte ignored
  sel_reg_bank #(
    .W (16)
  ) u_bank (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .wr_en_i   (sel_wr),
    .wr_idx_i  (pd_hit),
    .wr_data_i (reg_wdata_i),
    .rd_idx_i  (pd_hit),
    .rd_data_o (bank_rdata),
    .word0_o   (dac_word),
    .word1_o   (pd_word)
  );

  // Index kept only on a read, so idle cycles do not toggle it
  always_comb begin
    rd_pend_nxt = reg_rd_i;
    rd_idx_nxt  = rd_idx_r;
    if (reg_rd_i) begin
      rd_idx_nxt = reg_idx_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rd_pend_r <= 1'b0;
    end else begin
      rd_pend_r <= rd_pend_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rd_idx_r <= 2'h0;
    end else begin
      rd_idx_r <= rd_idx_nxt;
    end
  end

  // Bank read data is registered, so answer lands two cycles after the read request
  // Unmapped index falls to the default and reads zero
  always_comb begin
    rdata_nxt = 16'h0000;
    if (rd_pend_r) begin
      case (rd_idx_r)
        pin_sel_pkg::IDX_DAC_SEL:  rdata_nxt = bank_rdata;
        pin_sel_pkg::IDX_PD_SEL:   rdata_nxt = bank_rdata;
        pin_sel_pkg::IDX_GEN_CTRL: rdata_nxt = gen_ctrl_r;
        default:                   rdata_nxt = pin_sel_pkg::UNMAPPED_RDATA;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= rd_pend_r;
    end
  end

  // [R08] One-cycle pulse per refused write
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      refused_r <= 1'b0;
    end else begin
      refused_r <= sel_wr_refused;
    end
  end

  // [R01] DAC pin claims
  // [R05] Pull-down pin claims
  // [R02] Zero bits claim nothing
  always_comb begin
    analog_sel_nxt = pin_claims(dac_word);
    weak_gnd_nxt   = pin_claims(pd_word);
  end

  // [R03] No pin analog out of reset
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      analog_sel_r <= PINS'(pin_sel_pkg::DAC_SEL_RST);
    end else begin
      analog_sel_r <= analog_sel_nxt;
    end
  end

  // [R06] Every pin weakly grounded out of reset
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      weak_gnd_r <= PINS'(pin_sel_pkg::PD_SEL_RST);
    end else begin
      weak_gnd_r <= weak_gnd_nxt;
    end
  end

  // Lock copy for the cfg_locked_o port; lags the control word a cycle
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      locked_r <= 1'b0;
    end else begin
      locked_r <= lock;
    end
  end

  // Outputs driven straight from their flip-flops
  assign reg_rdata_o      = rdata_r;
  assign reg_rvalid_o     = rvalid_r;
  assign wr_refused_o     = refused_r;
  assign analog_out_sel_o = analog_sel_r;
  assign weak_gnd_sel_o   = weak_gnd_r;
  assign cfg_locked_o     = locked_r;
endmodule : dac_pin_select_and_pulldown_cfg

// ### dv/cfg_props.sv
// Timing and value checks on the pin selection register block
`timescale 1ns/1ps
module cfg_props #(
  parameter int PINS = 8
) (
  input wire logic            clk_i,
  input wire logic            resetn_i,
  input wire logic            reg_wr_i,
  input wire logic            reg_rd_i,
  input wire logic [1:0]      reg_idx_i,
  input wire logic [15:0]     reg_wdata_i,
  input wire logic [15:0]     reg_rdata_o,
  input wire logic            reg_rvalid_o,
  input wire logic            wr_refused_o,
  input wire logic [PINS-1:0] analog_out_sel_o,
  input wire logic [PINS-1:0] weak_gnd_sel_o,
  input wire logic            cfg_locked_o
);
  logic sel_req;
  logic lock_seen_r;

  assign sel_req = reg_wr_i && (reg_idx_i == pin_sel_pkg::IDX_DAC_SEL ||
                                reg_idx_i == pin_sel_pkg::IDX_PD_SEL);

  // Lock as the block applies it; the port copy lags a cycle
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      lock_seen_r <= 1'b0;
    end else if (reg_wr_i && reg_idx_i == pin_sel_pkg::IDX_GEN_CTRL) begin
      lock_seen_r <= reg_wdata_i[pin_sel_pkg::LOCK_BIT];
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  a_rd_latency: assert property (reg_rd_i |-> ##2 reg_rvalid_o)
    else $error("read answer late");
  a_rvalid_pulse: assert property (reg_rvalid_o |-> $past(reg_rd_i, 2))
    else $error("read answer without request");
  a_upper_zero: assert property (reg_rd_i
    && reg_idx_i != pin_sel_pkg::IDX_GEN_CTRL
    |-> ##2 reg_rdata_o[15:8] == 8'h00) else $error("upper byte set");
  a_dac_write: assert property (reg_wr_i && !lock_seen_r
    && reg_idx_i == pin_sel_pkg::IDX_DAC_SEL
    |-> ##2 analog_out_sel_o == $past(reg_wdata_i[PINS-1:0], 2))
    else $error("analog select wrong");
  a_pd_write: assert property (reg_wr_i && !lock_seen_r
    && reg_idx_i == pin_sel_pkg::IDX_PD_SEL
    |-> ##2 weak_gnd_sel_o == $past(reg_wdata_i[PINS-1:0], 2))
    else $error("pull-down select wrong");
  a_lock_refuse: assert property (sel_req && lock_seen_r
    |=> wr_refused_o) else $error("refusal missing");
  a_lock_hold: assert property (sel_req && lock_seen_r
    |-> ##2 $stable(analog_out_sel_o) && $stable(weak_gnd_sel_o))
    else $error("locked write took effect");
  a_no_refuse: assert property (wr_refused_o
    |-> $past(sel_req) && $past(lock_seen_r))
    else $error("spurious refusal");
  a_lock_mirror: assert property (cfg_locked_o == $past(lock_seen_r))
    else $error("lock output wrong");
  a_rst_values: assert property ($rose(resetn_i)
    |-> analog_out_sel_o == 0 && weak_gnd_sel_o == {PINS{1'b1}})
    else $error("reset value wrong");
endmodule : cfg_props
bind dac_pin_select_and_pulldown_cfg cfg_props #(
  .PINS (PINS)
) cfg_props_i (
  .clk_i            (clk_i),
  .resetn_i         (resetn_i),
  .reg_wr_i         (reg_wr_i),
  .reg_rd_i         (reg_rd_i),
  .reg_idx_i        (reg_idx_i),
  .reg_wdata_i      (reg_wdata_i),
  .reg_rdata_o      (reg_rdata_o),
  .reg_rvalid_o     (reg_rvalid_o),
  .wr_refused_o     (wr_refused_o),
  .analog_out_sel_o (analog_out_sel_o),
  .weak_gnd_sel_o   (weak_gnd_sel_o),
  .cfg_locked_o     (cfg_locked_o)
);

// ### dv/host_model.sv
// Register master standing in for the host controller
`timescale 1ns/1ps
module host_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rvalid_i,
  output logic             wr_o = 1'b0,
  output logic             rd_o = 1'b0,
  output logic [1:0]       idx_o = 2'h0,
  output logic [15:0]      wdata_o = 16'h0000
);
  task automatic wr(input logic [1:0] i, input logic [15:0] d);
    wr_o <= 1'b1;
    idx_o <= i;
    wdata_o <= d;
    @(posedge clk_i) wr_o <= 1'b0;
    @(posedge clk_i);
  endtask : wr
  // Answer is taken in its one valid cycle
  task automatic rd(input logic [1:0] i, output logic [15:0] q);
    rd_o <= 1'b1;
    idx_o <= i;
    @(posedge clk_i) rd_o <= 1'b0;
    repeat (2) @(posedge clk_i);
    q = rvalid_i ? rdata_i : 16'hDEAD;
  endtask : rd
endmodule : host_model

// ### dv/tb_top.sv
// Self-checking bench for the pin selection register block
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0, resetn_i = 1'b0, wr, rd, rv, refused, lk;
  logic [1:0] idx;
  logic [15:0] wd, rdat, q;
  logic [7:0] ana, wgs;
  int fail_count = 0, cmp_count = 0;
  always #5 clk_i = ~clk_i;
  dac_pin_select_and_pulldown_cfg dac_pin_select_and_pulldown_cfg_i (
    .clk_i(clk_i), .resetn_i(resetn_i), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_idx_i(idx), .reg_wdata_i(wd), .reg_rdata_o(rdat),
    .reg_rvalid_o(rv), .wr_refused_o(refused), .analog_out_sel_o(ana),
    .weak_gnd_sel_o(wgs), .cfg_locked_o(lk));
  host_model host_model_i (.clk_i(clk_i), .rdata_i(rdat), .rvalid_i(rv),
    .wr_o(wr), .rd_o(rd), .idx_o(idx), .wdata_o(wd));
  task automatic chk(input logic [15:0] g, e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic rchk(input logic [1:0] i, input logic [15:0] e);
    host_model_i.rd(i, q);
    chk(q, e);
  endtask : rchk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  task automatic t_reset;
    rchk(2'h0, 16'h0000);
    rchk(2'h1, 16'h00FF);
    chk({ana, wgs}, 16'h00FF);
  endtask : t_reset
  task automatic t_rw;
    host_model_i.wr(2'h0, 16'hFF5A);
    host_model_i.wr(2'h1, 16'hA5C3);
    rchk(2'h0, 16'h005A);
    chk({ana, wgs}, 16'h5AC3);
    host_model_i.wr(2'h0, 16'h0000);
    host_model_i.wr(2'h3, 16'hFFFF);
    rchk(2'h3, 16'h0000);
    chk({ana, wgs}, 16'h00C3);
    rchk(2'h1, 16'h00C3);
  endtask : t_rw
  task automatic t_lock;
    host_model_i.wr(2'h2, 16'h0080);
    host_model_i.wr(2'h0, 16'h00FF);
    chk({15'h0, refused}, 16'h0001);
    chk({15'h0, lk}, 16'h0001);
    rchk(2'h0, 16'h0000);
    rchk(2'h2, 16'h0080);
    host_model_i.wr(2'h2, 16'h0000);
    host_model_i.wr(2'h0, 16'h0081);
    chk({15'h0, lk}, 16'h0000);
    rchk(2'h0, 16'h0081);
  endtask : t_lock
  initial begin
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    t_reset();
    t_rw();
    t_lock();
    end_sim();
  end
  initial begin
    #100000;
    fail_count++;
    end_sim();
  end
endmodule : tb_top
